// File: rtl/mdd_ring_dma.sv
// descriptor ring dma engine for an ethernet mac that tags rx frames with one of four ports
// assumes same-clock mac streams and two memory ports that ack requests
`timescale 1ns/1ps
`include "mdd_regs.svh"
module mdd_ring_dma (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             rxMemReq,
    output logic             rxMemWe,
    output logic      [31:0] rxMemAddr,
    output logic      [31:0] rxMemWdata,
    input  wire logic [31:0] rxMemRdata,
    input  wire logic        rxMemAck,
    output logic             txMemReq,
    output logic      [31:0] txMemAddr,
    input  wire logic [31:0] txMemRdata,
    input  wire logic        txMemAck,
    input  wire logic        rxValid,
    input  wire logic [31:0] rxData,
    input  wire logic        rxLast,
    input  wire logic [1:0]  rxLastBytes,
    output logic             rxReady,
    input  wire logic        rxCrcErr,
    input  wire logic        rxRunt,
    input  wire logic        rxMcast,
    input  wire logic        rxPhyErr,
    input  wire logic        rxIpBad,
    input  wire logic        rxTcpBad,
    input  wire logic        rxUdpBad,
    input  wire logic [1:0]  rxPort,
    input  wire logic [15:0] rxLenType,
    output logic             txValid,
    output logic      [31:0] txData,
    output logic             txLast,
    output logic      [1:0]  txLastBytes,
    output logic      [2:0]  txSumInsert,
    input  wire logic        txReady,
    output logic             txIrq
);
    // ************************************************************
    // register file
    // ************************************************************
    logic [31:0] ctrl_r;
    logic [31:0] rxBase_r;
    logic [31:0] txBase_r;
    logic        rxPhyErr_r;
    mdd_pkg::mdd_rx_state_t rxState_r;
    mdd_pkg::mdd_tx_state_t txState_r;
    logic        setup;
    logic        wrAcc;
    logic        hit;

    function automatic logic [31:0] nextDesc(input logic eor,
                                             input logic [31:0] base,
                                             input logic [31:0] nxt);
        nextDesc = eor ? base : nxt;
    endfunction : nextDesc

    assign setup = psel & ~penable;
    assign wrAcc = psel & penable & pwrite;
    assign hit   = (paddr == `MDD_CTRL_OFS) || (paddr == `MDD_RXBASE_OFS) ||
                   (paddr == `MDD_TXBASE_OFS) || (paddr == `MDD_STAT_OFS);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_r   <= `MDD_CTRL_RST;
            rxBase_r <= 32'h0000_0000;
            txBase_r <= 32'h0000_0000;
        end else if (wrAcc) begin
            case (paddr)
                `MDD_CTRL_OFS:   ctrl_r   <= {28'h000_0000, pwdata[3:0]};
                `MDD_RXBASE_OFS: rxBase_r <= {pwdata[31:2], 2'b00};
                `MDD_TXBASE_OFS: txBase_r <= {pwdata[31:2], 2'b00};
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= 1'b1;
            if (setup) begin
                pslverr <= ~hit;
                case (paddr)
                    `MDD_CTRL_OFS:   prdata <= ctrl_r;
                    `MDD_RXBASE_OFS: prdata <= rxBase_r;
                    `MDD_TXBASE_OFS: prdata <= txBase_r;
                    `MDD_STAT_OFS:   prdata <= {24'h00_0000, 1'b0,
                                                txState_r, 1'b0, rxState_r};
                    default:         prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ************************************************************
    // receive engine
    // ************************************************************
    logic [31:0] rxDesc_r;
    logic [31:0] rxBuf_r;
    logic [31:0] rxNext_r;
    logic        rxEor_r;
    logic [11:0] rxSize_r;
    logic [11:0] rxOff_r;
    logic [1:0]  rxIdx_r;
    logic        rxFirst_r;
    logic        rxEnd_r;
    logic        rxDrop_r;
    logic [10:0] rxLen_r;
    logic [31:0] rxStat_r;
    logic [10:0] lenNow;
    logic        over;
    logic        runtNow;

    assign lenNow = rxLen_r + ((rxLastBytes == 2'b00) ? 11'd4
                                                     : {9'd0, rxLastBytes});
    assign over    = lenNow > `MDD_MAX_FRAME;
    assign runtNow = rxRunt;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rxState_r  <= mdd_pkg::RX_IDLE;
            rxDesc_r   <= 32'h0000_0000;
            rxBuf_r    <= 32'h0000_0000;
            rxNext_r   <= 32'h0000_0000;
            rxEor_r    <= 1'b0;
            rxSize_r   <= 12'h000;
            rxOff_r    <= 12'h000;
            rxIdx_r    <= 2'b00;
            rxFirst_r  <= 1'b1;
            rxEnd_r    <= 1'b0;
            rxDrop_r   <= 1'b0;
            rxLen_r    <= 11'h000;
            rxStat_r   <= 32'h0000_0000;
            rxPhyErr_r <= 1'b0;
            rxMemReq   <= 1'b0;
            rxMemWe    <= 1'b0;
            rxMemAddr  <= 32'h0000_0000;
            rxMemWdata <= 32'h0000_0000;
            rxReady    <= 1'b0;
        end else begin
            rxReady <= 1'b0;
            case (rxState_r)
                mdd_pkg::RX_IDLE: begin
                    if (!ctrl_r[`MDD_CTRL_RXEN]) begin
                        rxDesc_r  <= rxBase_r;
                        rxFirst_r <= 1'b1;
                    end else if (!rxMemReq) begin
                        rxIdx_r   <= 2'b00;
                        rxMemReq  <= 1'b1;
                        rxMemWe   <= 1'b0;
                        rxMemAddr <= rxDesc_r;
                        rxState_r <= mdd_pkg::RX_FETCH;
                    end
                end
                mdd_pkg::RX_FETCH: begin
                    if (!rxMemReq) begin
                        rxMemReq  <= 1'b1;
                        rxMemAddr <= rxDesc_r + {28'h000_0000, rxIdx_r,
                                                 2'b00};
                    end else if (rxMemAck) begin
                        rxMemReq <= 1'b0;
                        case (rxIdx_r)
                            2'd0: if (!rxMemRdata[`MDD_OWN_BIT]) begin
                                rxState_r <= mdd_pkg::RX_IDLE;
                            end
                            2'd1: begin
                                rxEor_r  <= rxMemRdata[`MDD_RXEOR_BIT];
                                rxSize_r <= rxMemRdata[11:0];
                            end
                            2'd2: rxBuf_r  <= rxMemRdata;
                            default: rxNext_r <= rxMemRdata;
                        endcase
                        if (rxIdx_r != 2'd0 || rxMemRdata[`MDD_OWN_BIT])
                        begin
                            if (rxIdx_r == 2'd3) begin
                                rxOff_r   <= 12'h000;
                                rxState_r <= (rxSize_r == 12'h000) ?
                                    mdd_pkg::RX_NEXT :
                                    mdd_pkg::RX_WAIT;
                            end else begin
                                rxIdx_r <= rxIdx_r + 2'd1;
                            end
                        end
                    end
                end
                mdd_pkg::RX_WAIT: begin
                    if (rxOff_r >= rxSize_r) begin
                        rxEnd_r   <= 1'b0;
                        rxStat_r  <= {1'b0, rxFirst_r, 30'h0000_0000};
                        rxState_r <= mdd_pkg::RX_STAT;
                    end else if (rxReady && rxValid) begin
                        rxMemReq   <= 1'b1;
                        rxMemWe    <= 1'b1;
                        rxMemAddr  <= rxBuf_r + {20'h0_0000, rxOff_r};
                        rxMemWdata <= rxData;
                        rxOff_r    <= rxOff_r + 12'd4;
                        rxLen_r    <= rxLast ? lenNow : rxLen_r + 11'd4;
                        rxPhyErr_r <= rxPhyErr_r | rxPhyErr;
                        rxEnd_r    <= rxLast;
                        rxDrop_r   <= rxLast & runtNow &
                                      ~ctrl_r[`MDD_CTRL_PASSBAD];
                        rxStat_r   <= {1'b0, rxFirst_r, 1'b1,
                            rxIpBad, rxTcpBad, rxUdpBad,
                            rxCrcErr | over | runtNow,
                            rxMcast,
                            2'b00, rxPort,
                            rxPhyErr_r | rxPhyErr,
                            over, runtNow, rxCrcErr,
                            (rxLenType > `MDD_TYPE_MIN) & ~runtNow,
                            4'h0, lenNow};
                        rxState_r  <= mdd_pkg::RX_DATA;
                    end else if (!rxReady) begin
                        rxReady <= 1'b1;
                    end
                end
                mdd_pkg::RX_DATA: begin
                    if (rxMemAck) begin
                        rxMemReq <= 1'b0;
                        rxMemWe  <= 1'b0;
                        if (rxEnd_r && rxDrop_r) begin
                            rxOff_r    <= 12'h000;
                            rxLen_r    <= 11'h000;
                            rxPhyErr_r <= 1'b0;
                            rxEnd_r    <= 1'b0;
                            rxState_r  <= mdd_pkg::RX_WAIT;
                        end else begin
                            rxState_r <= rxEnd_r ? mdd_pkg::RX_STAT
                                                 : mdd_pkg::RX_WAIT;
                        end
                    end
                end
                mdd_pkg::RX_STAT: begin
                    if (!rxMemReq) begin
                        rxMemReq   <= 1'b1;
                        rxMemWe    <= 1'b1;
                        rxMemAddr  <= rxDesc_r;
                        rxMemWdata <= rxStat_r;
                    end else if (rxMemAck) begin
                        rxMemReq  <= 1'b0;
                        rxMemWe   <= 1'b0;
                        rxFirst_r <= rxEnd_r;
                        if (rxEnd_r) begin
                            rxLen_r    <= 11'h000;
                            rxPhyErr_r <= 1'b0;
                        end
                        rxState_r <= mdd_pkg::RX_NEXT;
                    end
                end
                mdd_pkg::RX_NEXT: begin
                    rxDesc_r  <= nextDesc(rxEor_r, rxBase_r, rxNext_r);
                    rxState_r <= mdd_pkg::RX_IDLE;
                end
                default: rxState_r <= mdd_pkg::RX_IDLE;
            endcase
        end
    end

    // ************************************************************
    // transmit engine
    // ************************************************************
    logic [31:0] txDesc_r;
    logic [31:0] txBuf_r;
    logic [31:0] txNext_r;
    logic [31:0] txCtl_r;
    logic [10:0] txOff_r;
    logic [1:0]  txIdx_r;
    logic [10:0] txSize;
    logic [10:0] txRem;

    assign txSize = txCtl_r[10:0];
    assign txRem  = txSize - txOff_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            txState_r   <= mdd_pkg::TX_IDLE;
            txDesc_r    <= 32'h0000_0000;
            txBuf_r     <= 32'h0000_0000;
            txNext_r    <= 32'h0000_0000;
            txCtl_r     <= 32'h0000_0000;
            txOff_r     <= 11'h000;
            txIdx_r     <= 2'b00;
            txMemReq    <= 1'b0;
            txMemAddr   <= 32'h0000_0000;
            txValid     <= 1'b0;
            txData      <= 32'h0000_0000;
            txLast      <= 1'b0;
            txLastBytes <= 2'b00;
            txSumInsert <= 3'b000;
            txIrq       <= 1'b0;
        end else begin
            txIrq <= 1'b0;
            case (txState_r)
                mdd_pkg::TX_IDLE: begin
                    if (!ctrl_r[`MDD_CTRL_TXEN]) begin
                        txDesc_r <= txBase_r;
                    end else if (!txMemReq) begin
                        txIdx_r   <= 2'b00;
                        txMemReq  <= 1'b1;
                        txMemAddr <= txDesc_r;
                        txState_r <= mdd_pkg::TX_FETCH;
                    end
                end
                mdd_pkg::TX_FETCH: begin
                    if (!txMemReq) begin
                        txMemReq  <= 1'b1;
                        txMemAddr <= txDesc_r + {28'h000_0000, txIdx_r,
                                                 2'b00};
                    end else if (txMemAck) begin
                        txMemReq <= 1'b0;
                        case (txIdx_r)
                            2'd0: if (!txMemRdata[`MDD_OWN_BIT]) begin
                                txState_r <= mdd_pkg::TX_IDLE;
                            end
                            2'd1: txCtl_r  <= txMemRdata;
                            2'd2: txBuf_r  <= txMemRdata;
                            default: txNext_r <= txMemRdata;
                        endcase
                        if (txIdx_r != 2'd0 || txMemRdata[`MDD_OWN_BIT])
                        begin
                            if (txIdx_r == 2'd3) begin
                                txOff_r   <= 11'h000;
                                txState_r <= (txSize == 11'h000) ?
                                    mdd_pkg::TX_NEXT :
                                    mdd_pkg::TX_READ;
                            end else begin
                                txIdx_r <= txIdx_r + 2'd1;
                            end
                        end
                    end
                end
                mdd_pkg::TX_READ: begin
                    if (txOff_r >= txSize) begin
                        txState_r <= mdd_pkg::TX_STAT;
                    end else if (!txMemReq) begin
                        txMemReq  <= 1'b1;
                        txMemAddr <= txBuf_r + {21'h00_0000, txOff_r};
                    end else if (txMemAck) begin
                        txMemReq    <= 1'b0;
                        txValid     <= 1'b1;
                        txData      <= txMemRdata;
                        txLast      <= (txRem <= 11'd4) &
                                       txCtl_r[`MDD_LAST_BIT];
                        txLastBytes <= (txRem <= 11'd4) ? txRem[1:0]
                                                        : 2'b00;
                        txSumInsert <= ctrl_r[`MDD_CTRL_GSUM] ? 3'b000 :
                                       {txCtl_r[`MDD_IPINS_BIT],
                                        txCtl_r[`MDD_TCPINS_BIT],
                                        txCtl_r[`MDD_UDPINS_BIT]};
                        txOff_r     <= txOff_r + 11'd4;
                        txState_r   <= mdd_pkg::TX_SEND;
                    end
                end
                mdd_pkg::TX_SEND: begin
                    if (txReady) begin
                        txValid   <= 1'b0;
                        txState_r <= mdd_pkg::TX_READ;
                    end
                end
                mdd_pkg::TX_STAT: begin
                    if (!txMemReq) begin
                        txMemReq  <= 1'b1;
                        txMemAddr <= txDesc_r;
                    end else if (txMemAck) begin
                        txMemReq  <= 1'b0;
                        txIrq     <= txCtl_r[`MDD_TXIRQ_BIT] &
                                     txCtl_r[`MDD_LAST_BIT];
                        txState_r <= mdd_pkg::TX_NEXT;
                    end
                end
                mdd_pkg::TX_NEXT: begin
                    txDesc_r  <= nextDesc(txCtl_r[`MDD_TXEOR_BIT],
                                          txBase_r, txNext_r);
                    txState_r <= mdd_pkg::TX_IDLE;
                end
                default: txState_r <= mdd_pkg::TX_IDLE;
            endcase
        end
    end

endmodule : mdd_ring_dma

// File: pkg/mdd_regs.svh
// register offsets, field positions, reset values and limits of the engine
// assumes inclusion by bare name from the design files
`ifndef MDD_REGS_SVH
`define MDD_REGS_SVH
`define MDD_CTRL_OFS       12'h000
`define MDD_RXBASE_OFS     12'h004
`define MDD_TXBASE_OFS     12'h008
`define MDD_STAT_OFS       12'h00C
`define MDD_CTRL_RST       32'h0000_0000
`define MDD_CTRL_RXEN      0
`define MDD_CTRL_TXEN      1
`define MDD_CTRL_PASSBAD   2
`define MDD_CTRL_GSUM      3
`define MDD_OWN_BIT        31
`define MDD_FIRST_BIT      30
`define MDD_LAST_BIT       29
`define MDD_IPBAD_BIT      28
`define MDD_TCPBAD_BIT     27
`define MDD_UDPBAD_BIT     26
`define MDD_ERRSUM_BIT     25
`define MDD_MCAST_BIT      24
`define MDD_PORT_LSB       20
`define MDD_PHYERR_BIT     19
`define MDD_OVER_BIT       18
`define MDD_RUNT_BIT       17
`define MDD_CRC_BIT        16
`define MDD_TYPE_BIT       15
`define MDD_RXEOR_BIT      25
`define MDD_TXIRQ_BIT      31
`define MDD_TXEOR_BIT      25
`define MDD_IPINS_BIT      28
`define MDD_TCPINS_BIT     27
`define MDD_UDPINS_BIT     26
`define MDD_MAX_FRAME      11'h5EE
`define MDD_TYPE_MIN       16'h05DC
`endif

// File: pkg/mdd_pkg.sv
// types shared by the descriptor ring engine
// assumes nothing beyond a SystemVerilog compiler
package mdd_pkg;
    typedef enum logic [2:0] {
        RX_IDLE, RX_FETCH, RX_DATA, RX_WAIT, RX_STAT, RX_NEXT
    } mdd_rx_state_t;
    typedef enum logic [2:0] {
        TX_IDLE, TX_FETCH, TX_READ, TX_SEND, TX_STAT, TX_NEXT
    } mdd_tx_state_t;
endpackage : mdd_pkg

// File: verification/mdd_mem_model.sv
// word memory on one engine memory port, answering with ack pulses
// assumes requests held until ack and dropped right after it
`timescale 1ns/1ps
module mdd_mem_model (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        slow,
    input  wire logic        req,
    input  wire logic        we,
    input  wire logic [31:0] addr,
    input  wire logic [31:0] wdata,
    output logic      [31:0] rdata,
    output logic             ack
);
    // ****************************************
    // memory and answer
    // ****************************************
    logic [31:0] mem [0:255];
    logic [1:0]  waitCnt;
    always @(posedge clk) begin
        ack   <= 1'h0;
        rdata <= ~rdata;
        if (!resetn) begin
            waitCnt <= 2'h0;
        end else if (req && !ack && waitCnt < {slow, 1'h0}) begin
            waitCnt <= waitCnt + 2'h1;
        end else if (req && !ack) begin
            ack     <= 1'h1;
            waitCnt <= 2'h0;
            rdata   <= mem[addr[9:2]];
            if (we) mem[addr[9:2]] <= wdata;
        end
    end
endmodule : mdd_mem_model

// File: verification/mdd_ring_dma_assertions.sv
// port checks of the ring engine
// assumes binding onto every mdd_ring_dma
`timescale 1ns/1ps
module mdd_ring_dma_assertions (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rxMemReq,
    input wire logic        rxMemAck,
    input wire logic [31:0] rxMemAddr,
    input wire logic        txMemReq,
    input wire logic        txMemAck,
    input wire logic [31:0] txMemAddr,
    input wire logic        txValid,
    input wire logic        txReady,
    input wire logic [31:0] txData,
    input wire logic        txIrq
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_ready; $past(resetn) |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_miss; psel && penable && paddr > 12'h00C
        |-> pslverr && prdata == 32'h0; endproperty
    a_miss: assert property (p_miss) else $error("unmapped ok");
    property p_rxHold; rxMemReq && !rxMemAck
        |=> rxMemReq && $stable(rxMemAddr); endproperty
    a_rxHold: assert property (p_rxHold) else $error("rx req");
    property p_rxGap; rxMemReq && rxMemAck |=> !rxMemReq; endproperty
    a_rxGap: assert property (p_rxGap) else $error("rx gap");
    property p_txHold; txMemReq && !txMemAck
        |=> txMemReq && $stable(txMemAddr); endproperty
    a_txHold: assert property (p_txHold) else $error("tx req");
    property p_txGap; txMemReq && txMemAck |=> !txMemReq; endproperty
    a_txGap: assert property (p_txGap) else $error("tx gap");
    property p_align; rxMemReq |-> rxMemAddr[1:0] == 2'h0; endproperty
    a_align: assert property (p_align) else $error("rx addr");
    property p_txv; txValid && !txReady
        |=> txValid && $stable(txData); endproperty
    a_txv: assert property (p_txv) else $error("tx word");
    property p_irq; txIrq |=> !txIrq; endproperty
    a_irq: assert property (p_irq) else $error("irq long");
endmodule : mdd_ring_dma_assertions
bind mdd_ring_dma mdd_ring_dma_assertions u_chk (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxMemReq(rxMemReq), .rxMemAck(rxMemAck), .rxMemAddr(rxMemAddr),
    .txMemReq(txMemReq), .txMemAck(txMemAck), .txMemAddr(txMemAddr),
    .txValid(txValid), .txReady(txReady), .txData(txData), .txIrq(txIrq));

// File: verification/mdd_ring_dma_tb.sv
// bench: apb set-up, three rx frames (one a dropped runt), one tx frame over two rings
// assumes the memory model on both ports and the bound checker
`timescale 1ns/1ps
`include "mdd_regs.svh"
module mdd_ring_dma_tb;
    logic        clk, resetn, psel, penable, pwrite, pready, pslverr, errv;
    logic        rxMemReq, rxMemWe, rxMemAck, txMemReq, txMemAck, slow;
    logic        rxValid, rxLast, rxReady, rxCrcErr, rxRunt, rxMcast;
    logic        rxPhyErr, rxIpBad, rxTcpBad, rxUdpBad;
    logic        txValid, txLast, txReady, txIrq;
    logic [1:0]  rxLastBytes, rxPort, txLastBytes;
    logic [2:0]  txSumInsert;
    logic [11:0] paddr;
    logic [15:0] rxLenType;
    logic [31:0] pwdata, prdata, rxMemAddr, rxMemWdata, rxMemRdata, rdv;
    logic [31:0] txMemAddr, txMemRdata, rxData, txData, rxq[$], taq[$];
    logic [37:0] txq[$];
    int          err_total, check_count, irqs, j;
    mdd_ring_dma dut (.*);
    mdd_mem_model rxm (.clk(clk), .resetn(resetn), .slow(slow),
        .req(rxMemReq), .we(rxMemWe), .addr(rxMemAddr),
        .wdata(rxMemWdata), .rdata(rxMemRdata), .ack(rxMemAck));
    mdd_mem_model txm (.clk(clk), .resetn(resetn), .slow(~slow),
        .req(txMemReq), .we(1'h0), .addr(txMemAddr),
        .wdata(32'h0), .rdata(txMemRdata), .ack(txMemAck));
    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input logic [39:0] seen, want, input string what);
        check_count++;
        if (seen !== want) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'h1, wr, a, d};
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        {rdv, errv} = {prdata, pslverr};
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic rxw(input logic [31:0] d, input logic l,
                       input logic [1:0] b, input logic pe);
        @(posedge clk);
        {rxValid, rxData, rxLast} <= {1'h1, d, l};
        {rxLastBytes, rxPhyErr} <= {b, pe};
        {rxCrcErr, rxMcast, rxTcpBad, rxPort, rxRunt}
            <= {l, l, l, l, 1'h0, pe & l};
        rxLenType <= {4'h0, l, 11'h0};
        do @(negedge clk); while (rxReady !== 1'h1);
        @(posedge clk) rxValid <= 1'h0;
    endtask : rxw
    task automatic put(input logic tx, input int a, input logic [31:0] w[4]);
        foreach (w[k]) begin
            if (tx) txm.mem[a + k] = w[k];
            else rxm.mem[a + k] = w[k];
        end
    endtask : put
    // ****************************************
    // clock, far side traffic, watchdog, tests
    // ****************************************
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        slow    <= ~slow;
        txReady <= slow;
        if (rxMemReq && rxMemAck) rxq.push_back(rxMemAddr);
        if (txMemReq && txMemAck) taq.push_back(txMemAddr);
        if (txValid && txReady)
            txq.push_back({txSumInsert, txLastBytes, txLast, txData});
        if (txIrq) begin
            irqs++;
            txm.mem[8'h14] = 32'h0;
        end
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        test_done();
    end
    initial begin
        {resetn, psel, penable, pwrite, slow, txReady, paddr, pwdata} = '0;
        {rxValid, rxData, rxLast, rxLastBytes, rxPhyErr, rxRunt} = '0;
        {rxCrcErr, rxMcast, rxIpBad, rxTcpBad, rxUdpBad, rxPort} = '0;
        rxLenType = 16'h0;
        put(0, 8'h40, '{32'h8000_0000, 32'h0, 32'h300, 32'h110});
        put(0, 8'h44, '{32'h8000_0000, 32'h8, 32'h200, 32'h120});
        put(0, 8'h48, '{32'h8000_0000, 32'h0200_0008, 32'h210, 32'h130});
        put(1, 8'h10, '{32'h8000_0000, 32'h0, 32'h80, 32'h50});
        put(1, 8'h14, '{32'h8000_0000, 32'hF600_0008, 32'h80, 32'h60});
        put(1, 8'h20, '{32'hA1A2_A3A4, 32'hB1B2_B3B4, 32'h0, 32'h0});
        repeat (2) @(posedge clk);
        resetn <= 1'h1;
        apb(1'h0, `MDD_CTRL_OFS, 32'h0);
        check(rdv, `MDD_CTRL_RST, "ctrl");
        apb(1'h1, `MDD_RXBASE_OFS, 32'h100);
        apb(1'h1, `MDD_TXBASE_OFS, 32'h43);
        apb(1'h0, `MDD_TXBASE_OFS, 32'h0);
        check(rdv, 32'h40, "tx base");
        apb(1'h0, 12'h010, 32'h0);
        check({rdv, errv}, 33'h1, "unmapped");
        $display("test registers done");
        apb(1'h1, `MDD_CTRL_OFS, 32'h3);
        rxw(32'h1111_1111, 1'h0, 2'h0, 1'h1);
        rxw(32'h2222_2222, 1'h0, 2'h0, 1'h0);
        rxw(32'h3333_3333, 1'h1, 2'h2, 1'h0);
        while (rxm.mem[8'h48][31] !== 1'h0) @(negedge clk);
        check(rxm.mem[8'h40], 32'h8000_0000, "skipped");
        check(rxm.mem[8'h44], 32'h4000_0000, "rx first");
        check(rxm.mem[8'h48], 32'h2B29_800A, "rx last");
        check(rxm.mem[8'h48][25:0], 26'h329_800A, "rx st");
        check(rxm.mem[8'h80], 32'h1111_1111, "rx buf");
        check(rxm.mem[8'h84], 32'h3333_3333, "rx tail");
        $display("test receive done");
        while (irqs == 0) @(negedge clk);
        repeat (100) @(negedge clk);
        foreach (taq[k]) if (taq[k] == 32'h84) j = k;
        check(taq[j + 1], 32'h50, "write back");
        check(taq[j + 2], 32'h40, "tx ring");
        check(irqs, 40'h1, "irq count");
        check(txq.size(), 40'h2, "tx words");
        check({txq[0][37:35], txq[0][32:0]}, 36'hA_A1A2_A3A4, "tx 1");
        check(txq[1], {6'h29, 32'hB1B2_B3B4}, "tx 2");
        foreach (rxq[k]) if (rxq[k] == 32'h120) j = k;
        check(rxq[j + 1], 32'h100, "rx ring");
        $display("test transmit done");
        rxm.mem[8'h44] = 32'h8000_0000;
        rxw(32'h5555_5555, 1'h1, 2'h0, 1'h1);
        rxw(32'h4444_4444, 1'h1, 2'h0, 1'h0);
        while (rxm.mem[8'h44][31] !== 1'h0) @(negedge clk);
        check(rxm.mem[8'h44], 32'h6B21_8004, "runt drop");
        check(rxm.mem[8'h80], 32'h4444_4444, "runt over");
        $display("test runt done");
        test_done();
    end
endmodule : mdd_ring_dma_tb
